// >>> hdl/ifcd_map.svh
/*
  Constants for the input function configuration decoder: bit positions of the
  setup word, field widths, reserved mask and reset value.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IFCD_MAP_SVH
`define IFCD_MAP_SVH

`define IFCD_CFG_W          16              // setup word width
`define IFCD_CFG_RESET      16'h0000        // setup word after reset
`define IFCD_RSVD_MASK      16'h13c0        // bit 12 and bits 9..6 reserved
`define IFCD_BIT_QUAL_EN    11              // use network home qualifier
`define IFCD_BIT_ENC_EN     10              // use built-in encoder
`define IFCD_IN2_SEL_HI     5               // input 2 selector msb
`define IFCD_IN2_SEL_LO     3               // input 2 selector lsb
`define IFCD_IN1_SEL_HI     2               // input 1 selector msb
`define IFCD_IN1_SEL_LO     0               // input 1 selector lsb
`define IFCD_SEL_W          3               // selector width
`define IFCD_POS_W          32              // encoder position width

`endif

// >>> hdl/ifcd_pkg.sv
/*
  Types shared by the input function configuration decoder.
  Assumes ifcd_map.svh is on the include path.
*/
`include "ifcd_map.svh"

package ifcd_pkg;

  // input function selector codes
  typedef enum logic [`IFCD_SEL_W-1:0] {
    IFCD_FN_GP      = 3'h0,   // general purpose, reported only
    IFCD_FN_CW_LIM  = 3'h1,   // clockwise_travel_limit
    IFCD_FN_CCW_LIM = 3'h2,   // counterclockwise_travel_limit
    IFCD_FN_INDEX   = 3'h3,   // start indexed move
    IFCD_FN_STOP    = 3'h4,   // stop jog or registration move
    IFCD_FN_ESTOP   = 3'h5,   // emergency stop
    IFCD_FN_HOME    = 3'h6,   // home switch
    IFCD_FN_BAD     = 3'h7    // reserved combination
  } ifcd_fn_e;

  // per-input edge information
  typedef struct packed {
    logic level;   // current active state
    logic rise;    // inactive-to-active this cycle
    logic change;  // any transition this cycle
  } ifcd_evt_s;

endpackage

// >>> hdl/ifcd_edge.sv
/*
  Edge detector for one discrete input.
  Assumes the input is already corrected for its active level and synchronous to clk.
*/
`timescale 1ns/1ps

module ifcd_edge (
  input  wire logic          clk,    // device clock
  input  wire logic          rst_n,  // async reset, active low
  input  wire logic          din,    // input, 1 = active
  output ifcd_pkg::ifcd_evt_s evt    // level and edge flags
);

  logic prev_reg;   // input one cycle ago
  logic prev_next;  // next value of prev_reg

  // next value: simply follow the input
  always_comb begin
    prev_next = din;
  end

  // register; reset as inactive so an input active at reset gives one rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // combinational edge flags
  always_comb begin
    evt.level  = din;
    evt.rise   = din & ~prev_reg;
    evt.change = din ^ prev_reg;
  end

endmodule

// >>> hdl/ifcd_top.sv
/*
  Input function configuration decoder: stores the setup word, validates it,
  decodes the function of two discrete inputs and drives motion requests.
  Assumes inputs synchronous to clk, already corrected for active level; the
  motion sequencer consumes the one-cycle request pulses.

*/
`timescale 1ns/1ps
`include "ifcd_map.svh"

module ifcd_top #(
  parameter int POS_W = `IFCD_POS_W   // encoder position width
) (
  input  wire logic                  clk,           // device clock, 25 MHz
  input  wire logic                  rst_n,         // async reset, active low
  input  wire logic                  cfg_wr,        // setup word write strobe
  input  wire logic [`IFCD_CFG_W-1:0] cfg_wdata,    // setup word write data
  input  wire logic                  in1,           // discrete input 1, 1 = active
  input  wire logic                  in2,           // discrete input 2, 1 = active
  input  wire logic                  home_qual,     // network home qualifier bit
  input  wire logic                  index_pending, // indexed move waiting
  input  wire logic                  jog_running,   // jog or registration move running
  input  wire logic [POS_W-1:0]      enc_pos,       // live encoder position
  output logic [`IFCD_CFG_W-1:0]     cfg_rdata,     // stored setup word
  output logic                       cfg_error,     // last write was invalid
  output logic                       enc_enable,    // built-in encoder in use
  output logic                       qual_enable,   // qualifier in use
  output logic [1:0]                 input_status,  // input levels for host
  output logic                       clockwise_travel_limit,      // clockwise_travel_limit active
  output logic                       counterclockwise_travel_limit,     // counterclockwise_travel_limit active
  output logic                       home_switch,   // qualified home switch level
  output logic                       home_hunt,     // qualifier seen, hunting home
  output logic                       index_start,   // pulse: start indexed move
  output logic                       jog_stop,      // pulse: controlled stop
  output logic                       estop,         // pulse: immediate stop
  output logic                       capture_valid, // pulse: position captured
  output logic [POS_W-1:0]           capture_pos    // captured encoder position
);

  // selector of one input from a setup word
  function automatic ifcd_pkg::ifcd_fn_e sel_of(input logic [`IFCD_CFG_W-1:0] w,
                                                  input logic second);
    if (second) begin
      sel_of = ifcd_pkg::ifcd_fn_e'(w[`IFCD_IN2_SEL_HI:`IFCD_IN2_SEL_LO]);
    end else begin
      sel_of = ifcd_pkg::ifcd_fn_e'(w[`IFCD_IN1_SEL_HI:`IFCD_IN1_SEL_LO]);
    end
  endfunction

  // validity of a candidate setup word
  function automatic logic word_ok(input logic [`IFCD_CFG_W-1:0] w);
    ifcd_pkg::ifcd_fn_e s1;
    ifcd_pkg::ifcd_fn_e s2;
    s1 = sel_of(w, 1'b0);
    s2 = sel_of(w, 1'b1);
    word_ok = 1'b1;
    if ((w & `IFCD_RSVD_MASK) != 16'h0000) begin
      word_ok = 1'b0;
    end
    if (s1 == ifcd_pkg::IFCD_FN_BAD || s2 == ifcd_pkg::IFCD_FN_BAD) begin
      word_ok = 1'b0;
    end
    if (s1 == s2 && s1 != ifcd_pkg::IFCD_FN_GP) begin
      word_ok = 1'b0;
    end
  endfunction

  // configuration state
  logic [`IFCD_CFG_W-1:0] raw_reg, raw_next;    // last written word, readback
  logic [`IFCD_CFG_W-1:0] act_reg, act_next;    // last valid word, in force
  logic                   err_reg, err_next;    // invalid-write flag

  // home qualifier state
  logic qual_prev_reg, qual_prev_next;          // qualifier one cycle ago
  logic armed_reg, armed_next;                  // qualifier rise seen

  // output registers
  logic [1:0]       stat_reg, stat_next;
  logic             cw_reg, cw_next;
  logic             ccw_reg, ccw_next;
  logic             home_reg, home_next;
  logic             idx_reg, idx_next;
  logic             stop_reg, stop_next;
  logic             es_reg, es_next;
  logic             capv_reg, capv_next;
  logic [POS_W-1:0] capp_reg, capp_next;

  // decoded fields of the word in force
  ifcd_pkg::ifcd_fn_e fn1, fn2;                 // input functions
  logic               enc_en, qual_en;          // feature enables
  ifcd_pkg::ifcd_evt_s ev1, ev2;                // edge info per input

  assign fn1     = sel_of(act_reg, 1'b0);
  assign fn2     = sel_of(act_reg, 1'b1);
  assign enc_en  = act_reg[`IFCD_BIT_ENC_EN];
  assign qual_en = act_reg[`IFCD_BIT_QUAL_EN];

  // one edge detector per input
  ifcd_edge u_edge1 (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (in1),
    .evt   (ev1)
  );

  ifcd_edge u_edge2 (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (in2),
    .evt   (ev2)
  );

  // configuration write: a bad word is stored for readback but not applied
  always_comb begin
    raw_next = raw_reg;
    act_next = act_reg;
    err_next = err_reg;
    if (cfg_wr) begin
      raw_next = cfg_wdata;
      if (word_ok(cfg_wdata)) begin
        act_next = cfg_wdata;
        err_next = 1'b0;
      end else begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= `IFCD_CFG_RESET;
      act_reg <= `IFCD_CFG_RESET;
      err_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      act_reg <= act_next;
      err_reg <= err_next;
    end
  end

  // qualifier arming: once armed it stays until qualifier use is turned off,
  // since the hunt starts on the rise even if the bit later falls
  always_comb begin
    qual_prev_next = home_qual;
    armed_next     = armed_reg;
    if (!qual_en) begin
      armed_next = 1'b0;
    end else if (home_qual && !qual_prev_reg) begin
      armed_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qual_prev_reg <= 1'b0;
      armed_reg     <= 1'b0;
    end else begin
      qual_prev_reg <= qual_prev_next;
      armed_reg     <= armed_next;
    end
  end

  // function decode; duplicates other than general purpose are refused, so each function has one source
  always_comb begin
    logic home_lvl;
    home_lvl  = 1'b0;
    stat_next = {ev2.level, ev1.level};
    cw_next   = 1'b0;
    ccw_next  = 1'b0;
    idx_next  = 1'b0;
    stop_next = 1'b0;
    es_next   = 1'b0;
    capv_next = 1'b0;
    capp_next = capp_reg;
    // clockwise / counterclockwise limits follow the level
    if (fn1 == ifcd_pkg::IFCD_FN_CW_LIM) begin
      cw_next = ev1.level;
    end
    if (fn2 == ifcd_pkg::IFCD_FN_CW_LIM) begin
      cw_next = ev2.level;
    end
    if (fn1 == ifcd_pkg::IFCD_FN_CCW_LIM) begin
      ccw_next = ev1.level;
    end
    if (fn2 == ifcd_pkg::IFCD_FN_CCW_LIM) begin
      ccw_next = ev2.level;
    end
    // index start: rising edge only, and only with a move pending
    if ((fn1 == ifcd_pkg::IFCD_FN_INDEX && ev1.rise) ||
        (fn2 == ifcd_pkg::IFCD_FN_INDEX && ev2.rise)) begin
      idx_next = index_pending;
    end
    // index input captures on every transition when encoder is in use
    if (enc_en && ((fn1 == ifcd_pkg::IFCD_FN_INDEX && ev1.change) ||
                   (fn2 == ifcd_pkg::IFCD_FN_INDEX && ev2.change))) begin
      capv_next = 1'b1;
      capp_next = enc_pos;
    end
    // controlled stop of a running jog or registration move
    if (jog_running && ((fn1 == ifcd_pkg::IFCD_FN_STOP && ev1.rise) ||
                        (fn2 == ifcd_pkg::IFCD_FN_STOP && ev2.rise))) begin
      stop_next = 1'b1;
      if (enc_en) begin
        capv_next = 1'b1;
        capp_next = enc_pos;
      end
    end
    // emergency stop on rising edge
    if ((fn1 == ifcd_pkg::IFCD_FN_ESTOP && ev1.rise) ||
        (fn2 == ifcd_pkg::IFCD_FN_ESTOP && ev2.rise)) begin
      es_next = 1'b1;
    end
    // home switch level
    if (fn1 == ifcd_pkg::IFCD_FN_HOME) begin
      home_lvl = ev1.level;
    end
    if (fn2 == ifcd_pkg::IFCD_FN_HOME) begin
      home_lvl = ev2.level;
    end
    // with qualifier use on and no qualifier rise, the switch is masked, so homing never completes
    home_next = home_lvl & (~qual_en | armed_reg);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= 2'h0;
      cw_reg   <= 1'b0;
      ccw_reg  <= 1'b0;
      home_reg <= 1'b0;
      idx_reg  <= 1'b0;
      stop_reg <= 1'b0;
      es_reg   <= 1'b0;
      capv_reg <= 1'b0;
      capp_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      cw_reg   <= cw_next;
      ccw_reg  <= ccw_next;
      home_reg <= home_next;
      idx_reg  <= idx_next;
      stop_reg <= stop_next;
      es_reg   <= es_next;
      capv_reg <= capv_next;
      capp_reg <= capp_next;
    end
  end

  // outputs straight from flip-flops
  assign cfg_rdata     = raw_reg;
  assign cfg_error     = err_reg;
  assign enc_enable    = act_reg[`IFCD_BIT_ENC_EN];
  assign qual_enable   = act_reg[`IFCD_BIT_QUAL_EN];
  assign input_status  = stat_reg;
  assign clockwise_travel_limit      = cw_reg;
  assign counterclockwise_travel_limit     = ccw_reg;
  assign home_switch   = home_reg;
  assign home_hunt     = armed_reg;
  assign index_start   = idx_reg;
  assign jog_stop      = stop_reg;
  assign estop         = es_reg;
  assign capture_valid = capv_reg;
  assign capture_pos   = capp_reg;

endmodule

// >>> testbench/ifcd_top_properties.sv
/*
  Checker for ifcd_top: timing of setup word writes and input functions.
  Assumes ifcd_map.svh on the include path; bound to ifcd_top below.
*/
`timescale 1ns/1ps
`include "ifcd_map.svh"
module ifcd_top_properties #(
  parameter int POS_W = 32  // encoder position width
) (
  input wire logic                   clk,           // device clock
  input wire logic                   rst_n,         // async reset, active low
  input wire logic                   cfg_wr,        // write strobe
  input wire logic [`IFCD_CFG_W-1:0] cfg_wdata,     // write data
  input wire logic                   in1,           // discrete input 1
  input wire logic                   in2,           // discrete input 2
  input wire logic                   home_qual,     // network qualifier
  input wire logic                   index_pending, // index waiting
  input wire logic                   jog_running,   // jog running
  input wire logic [POS_W-1:0]       enc_pos,       // live position
  input wire logic                   cfg_error,     // refused write
  input wire logic                   enc_enable,    // encoder in use
  input wire logic                   qual_enable,   // qualifier in use
  input wire logic                   home_hunt,     // hunting home
  input wire logic                   index_start,   // index pulse
  input wire logic                   jog_stop,      // stop pulse
  input wire logic                   estop,         // emergency pulse
  input wire logic                   capture_valid, // capture pulse
  input wire logic [POS_W-1:0]       capture_pos    // captured position
);
  logic [15:0] live_reg;  // shadow of word in force
  logic [15:0] live_next; // next shadow value
  logic        word_bad;  // write would be refused
  // shadow follows valid writes only, so refusals keep old functions
  always_comb begin
    word_bad = (|(cfg_wdata & `IFCD_RSVD_MASK)) || (&cfg_wdata[2:0]) || (&cfg_wdata[5:3])
      || (cfg_wdata[2:0] == cfg_wdata[5:3] && |cfg_wdata[2:0]);
    live_next = (cfg_wr && !word_bad) ? cfg_wdata : live_reg;
  end
  // shadow register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_reg <= `IFCD_CFG_RESET;
    end else begin
      live_reg <= live_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  enc_bit_a: assert property (cfg_wr && !word_bad |=> enc_enable == $past(cfg_wdata[10]))
    else $error("encoder enable does not follow bit 10");
  qual_bit_a: assert property (cfg_wr && !word_bad |=> qual_enable == $past(cfg_wdata[11]))
    else $error("qualifier enable does not follow bit 11");
  bad_keep_a: assert property (cfg_wr && word_bad |=> cfg_error && $stable(enc_enable))
    else $error("refused write not flagged or changed state");
  good_clear_a: assert property (cfg_wr && !word_bad |=> !cfg_error)
    else $error("valid write left error set");
  estop_rise_a: assert property ($rose(in1) && live_reg[2:0] == 3'h5 |=> estop)
    else $error("emergency stop pulse missing");
  index_rise_a: assert property ($rose(in1) && live_reg[2:0] == 3'h3 && index_pending
    |=> index_start)
    else $error("index start pulse missing");
  jog_stop_a: assert property ($rose(in2) && live_reg[5:3] == 3'h4 && jog_running
    |=> jog_stop)
    else $error("controlled stop pulse missing");
  index_cap_a: assert property ($changed(in1) && live_reg[2:0] == 3'h3 && live_reg[10]
    |=> capture_valid && capture_pos == $past(enc_pos))
    else $error("index input capture wrong");
  gp_quiet_a: assert property (live_reg[5:0] == 6'h00 |=> !estop && !jog_stop && !index_start)
    else $error("general purpose inputs caused motion");
  hunt_start_a: assert property (qual_enable && $rose(home_qual) |=> home_hunt)
    else $error("home hunt not started on qualifier");
  cover property (cfg_wr && word_bad);
  cover property (capture_valid);
  cover property (home_hunt);
endmodule

bind ifcd_top ifcd_top_properties #(.POS_W(POS_W)) chk_u (.clk(clk), .rst_n(rst_n),
  .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .in1(in1), .in2(in2), .home_qual(home_qual),
  .index_pending(index_pending), .jog_running(jog_running), .enc_pos(enc_pos),
  .cfg_error(cfg_error), .enc_enable(enc_enable), .qual_enable(qual_enable),
  .home_hunt(home_hunt), .index_start(index_start), .jog_stop(jog_stop), .estop(estop),
  .capture_valid(capture_valid), .capture_pos(capture_pos));

// >>> testbench/ifcd_host_model.sv
/*
  Host side model: turns a bench request into a one-cycle setup word write.
  Assumes the bench raises req for one cycle per write.
*/
`timescale 1ns/1ps
`include "ifcd_map.svh"
module ifcd_host_model (
  input  wire logic        clk,       // device clock
  input  wire logic        rst_n,     // async reset, active low
  input  wire logic        req,       // write request from bench
  input  wire logic        allow_bad, // pass refused words unchanged
  input  wire logic [15:0] req_word,  // word to write
  output logic             cfg_wr,    // write strobe
  output logic [15:0]      cfg_wdata  // write data
);
  logic [15:0] clean; // word a careful host would send
  localparam logic [15:0] ENC_RES = 16'h0800; // resolution sent with encoder on
  logic [15:0] enc_res_reg; // resolution parameter last programmed
  // a host that turns the encoder on programs its resolution alongside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_res_reg <= 16'h0000;
    end else if (req && req_word[10]) begin
      enc_res_reg <= ENC_RES;
    end
  end
  // careful host clears reserved bits and never sends selector 111
  always_comb begin
    clean = req_word & ~`IFCD_RSVD_MASK;
    if (&clean[2:0]) begin
      clean[2:0] = 3'h0;
    end
    if (&clean[5:3]) begin
      clean[5:3] = 3'h0;
    end
  end
  // data is inverted when idle so a stale word is never mistaken for fresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr    <= 1'b0;
      cfg_wdata <= 16'h0000;
    end else begin
      cfg_wr    <= req;
      cfg_wdata <= req ? (allow_bad ? req_word : clean) : ~cfg_wdata;
    end
  end
endmodule

// >>> testbench/input_function_config_decode_tb.sv
/*
  Self-checking bench for ifcd_top with the host model in front of it.
  Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps
module input_function_config_decode_tb;
  logic        clk;                   // 25 MHz clock
  logic        rst_n;                 // reset, active low
  logic        req;                   // write request
  logic        allow_bad;             // send refused words
  logic [15:0] req_word;              // requested word
  logic        cfg_wr;                // strobe from host
  logic [15:0] cfg_wdata;             // data from host
  logic        in1, in2, home_qual;   // sensor and qualifier levels
  logic        index_pending;         // index waiting
  logic        jog_running;           // jog running
  logic [31:0] enc_pos, capture_pos;  // positions
  logic [15:0] cfg_rdata;             // stored word
  logic        cfg_error, enc_enable, qual_enable, home_hunt, capture_valid;
  logic [1:0]  input_status;          // reported levels
  logic [5:0]  ev;                    // cw,ccw,index,jog,estop,home
  int          error_cnt;             // mismatches
  int          total_checks;          // comparisons

  ifcd_host_model host_u (.clk(clk), .rst_n(rst_n), .req(req), .allow_bad(allow_bad),
    .req_word(req_word), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));
  ifcd_top dut_u (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .in1(in1), .in2(in2), .home_qual(home_qual), .index_pending(index_pending),
    .jog_running(jog_running), .enc_pos(enc_pos), .cfg_rdata(cfg_rdata),
    .cfg_error(cfg_error), .enc_enable(enc_enable), .qual_enable(qual_enable),
    .input_status(input_status), .clockwise_travel_limit(ev[5]), .counterclockwise_travel_limit(ev[4]),
    .home_switch(ev[0]), .home_hunt(home_hunt), .index_start(ev[3]), .jog_stop(ev[2]),
    .estop(ev[1]), .capture_valid(capture_valid), .capture_pos(capture_pos));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one write through the host; returns once outputs have settled
  task automatic wr(input logic [15:0] w, input logic bad);
    @(posedge clk);
    req       <= 1'b1;
    req_word  <= w;
    allow_bad <= bad;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // reset value, good write, every refusal kind, both general purpose
  task automatic t_config();
    logic [15:0] bad_w [6] = '{16'h1000, 16'h0040, 16'h0200, 16'h0007, 16'h0038, 16'h0009};
    chk("cfg_rdata", 32'h0, 32'(cfg_rdata));
    wr(16'h0c1a, 1'b0);
    chk("enc_enable", 32'h1, 32'(enc_enable));
    chk("qual_enable", 32'h1, 32'(qual_enable));
    foreach (bad_w[i]) begin
      wr(bad_w[i], 1'b1);
      chk("cfg_error", 32'h1, 32'(cfg_error));
      chk("enc_kept", 32'h1, 32'(enc_enable));
      chk("cfg_rdata", 32'(bad_w[i]), 32'(cfg_rdata));
    end
    wr(16'h0000, 1'b0);
    chk("cfg_error", 32'h0, 32'(cfg_error));
    $display("test config done");
  endtask
  // selectors 1 to 6 on each input, rise then fall
  task automatic t_funcs();
    logic [31:0] pos;
    @(posedge clk);
    index_pending <= 1'b1;
    jog_running   <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      for (int s = 1; s < 7; s++) begin
        pos = 32'hc0de0000 + 32'(s);
        wr(16'h0400 | (16'(s) << (3 * i)), 1'b0);
        @(posedge clk);
        in1     <= (i == 0);
        in2     <= (i == 1);
        enc_pos <= pos;
        @(posedge clk);
        #1;
        chk("function_out", 32'(6'h20 >> (s - 1)), 32'(ev));
        chk("capture_valid", 32'(s == 3 || s == 4), 32'(capture_valid));
        if (s == 3 || s == 4) chk("capture_pos", pos, capture_pos);
        chk("input_status", 32'(i + 1), 32'(input_status));
        @(posedge clk);
        in1 <= 1'b0;
        in2 <= 1'b0;
        @(posedge clk);
        #1;
        chk("capture_fall", 32'(s == 3), 32'(capture_valid));
      end
    end
    $display("test functions done");
  endtask
  // home switch ignored until the qualifier rises
  task automatic t_qual();
    wr(16'h0806, 1'b0);
    @(posedge clk);
    in1 <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("home_blocked", 32'h0, 32'(ev[0]));
    @(posedge clk);
    home_qual <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("home_hunt", 32'h1, 32'(home_hunt));
    @(posedge clk);
    #1;
    chk("home_switch", 32'h1, 32'(ev[0]));
    $display("test qualifier done");
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // main sequence
  initial begin
    {rst_n, req, allow_bad, in1, in2, home_qual, index_pending, jog_running} = 8'h00;
    req_word = 16'h0000;
    enc_pos  = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_config();
    t_funcs();
    t_qual();
    finish_test();
  end
  // watchdog, far beyond the 130 or so cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
